// file: common/lpm_pkg.sv
package lpm_pkg;

    // Power mode encodings, in the order software writes them.
    typedef enum logic [2:0] {
        full_run_mode,
        sleep_level_zero,
        sleep_level_one,
        sleep_level_two,
        sleep_level_three,
        sleep_level_four
    } mode_t;

    typedef struct packed {
        logic cpu_en;
        logic aux_clk_en;
        logic sub_main_clk_en;
        logic main_clk_en;
        logic freq_lock_regulation_en;
        logic osc_clk_en;
        logic dc_gen_en;
        logic crystal_en;
    } gate_t;

    localparam mode_t MODE_RESET = full_run_mode;
    localparam mode_t MODE_LAST = sleep_level_four;

    localparam gate_t GATE_RUN = 8'hff;
    localparam gate_t GATE_SLEEP0 = 8'h7f;
    localparam gate_t GATE_SLEEP1 = 8'h77;
    localparam gate_t GATE_SLEEP2 = 8'h43;
    localparam gate_t GATE_SLEEP3 = 8'h41;
    localparam gate_t GATE_SLEEP4 = 8'h00;

    localparam logic [31:0] MODE_CTRL_ADDR = 32'h0000_0000;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
    localparam logic [31:0] FAULT_ADDR = 32'h0000_0008;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int ST_SAVED_LSB = 4;
    localparam int ST_DEPTH_LSB = 8;
    localparam int ST_DEPTH_W = 4;
    localparam int ST_GATE_LSB = 16;
    localparam int ST_GATE_W = 8;
    localparam int FAULT_BAD_MODE_BIT = 0;
    localparam int FAULT_OVF_BIT = 1;
    localparam int FAULT_UNF_BIT = 2;
    localparam int NEST_DEPTH_DEF = 4;

endpackage

// file: common/reg_access_if.sv
`timescale 1ns/100ps
interface reg_access_if;
    logic wr_go;
    logic [31:0] wr_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] wr_resp;
    logic rd_go;
    logic [31:0] rd_addr;
    logic [31:0] rdata;
    logic [1:0] rd_resp;

    modport port (
        output wr_go, wr_addr, wdata, wstrb, rd_go, rd_addr,
        input wr_resp, rdata, rd_resp
    );
    modport regs (
        input wr_go, wr_addr, wdata, wstrb, rd_go, rd_addr,
        output wr_resp, rdata, rd_resp
    );
endinterface

// file: rtl/axil_reg_port.sv
`timescale 1ns/100ps
module axil_reg_port (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    reg_access_if.port ra
);
    typedef struct packed {
        logic aw_have;
        logic w_have;
        logic ar_have;
        logic bvalid;
        logic rvalid;
        logic [31:0] wr_addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] rd_addr;
        logic [31:0] rdata;
        logic [1:0] bresp;
        logic [1:0] rresp;
    } port_state_t;

    port_state_t s_r;
    port_state_t s_nxt;

    // Address and data are held until both are present, then applied once.
    always_comb begin
        s_nxt = s_r;
        awready = !s_r.aw_have && !s_r.bvalid;
        wready = !s_r.w_have && !s_r.bvalid;
        arready = !s_r.ar_have && !s_r.rvalid;
        if (awvalid && awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.wr_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_nxt.w_have = 1'b1;
            s_nxt.wdata = wdata;
            s_nxt.wstrb = wstrb;
        end
        if (s_r.aw_have && s_r.w_have) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = ra.wr_resp;
        end
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            s_nxt.ar_have = 1'b1;
            s_nxt.rd_addr = araddr;
        end
        if (s_r.ar_have) begin
            s_nxt.ar_have = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = ra.rdata;
            s_nxt.rresp = ra.rd_resp;
        end
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ra.wr_go = s_r.aw_have && s_r.w_have;
    assign ra.wr_addr = s_r.wr_addr;
    assign ra.wdata = s_r.wdata;
    assign ra.wstrb = s_r.wstrb;
    assign ra.rd_go = s_r.ar_have;
    assign ra.rd_addr = s_r.rd_addr;
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = s_r.rresp;
endmodule // axil_reg_port

// file: rtl/mode_gate_decode.sv
`timescale 1ns/100ps
module mode_gate_decode (
    input wire logic clk_sys,
    input wire logic reset,
    input wire lpm_pkg::mode_t mode,
    output lpm_pkg::gate_t gate
);
    typedef struct packed {
        lpm_pkg::gate_t gate;
    } dec_state_t;

    dec_state_t s_r;
    dec_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        case (mode)
            lpm_pkg::full_run_mode: begin
                s_nxt.gate = lpm_pkg::GATE_RUN;
            end
            lpm_pkg::sleep_level_zero: begin
                s_nxt.gate = lpm_pkg::GATE_SLEEP0;
            end
            lpm_pkg::sleep_level_one: begin
                s_nxt.gate = lpm_pkg::GATE_SLEEP1;
            end
            lpm_pkg::sleep_level_two: begin
                s_nxt.gate = lpm_pkg::GATE_SLEEP2;
            end
            lpm_pkg::sleep_level_three: begin
                s_nxt.gate = lpm_pkg::GATE_SLEEP3;
            end
            lpm_pkg::sleep_level_four: begin
                s_nxt.gate = lpm_pkg::GATE_SLEEP4;
            end
            default: s_nxt.gate = lpm_pkg::GATE_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_r.gate <= lpm_pkg::GATE_RUN;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign gate = s_r.gate;

    ////////////////////////////////////////////////////////////////////////
    property p_run_all_on;
        @(posedge clk_sys) disable iff (reset)
        mode == lpm_pkg::full_run_mode |=> &gate;
    endproperty
    a_run_all_on: assert property (p_run_all_on)
        else $error("Full run mode left a clock gated.");

    property p_sleep0;
        @(posedge clk_sys) disable iff (reset)
        mode == lpm_pkg::sleep_level_zero |=> !gate.cpu_en &&
            gate.aux_clk_en && gate.sub_main_clk_en &&
            gate.main_clk_en && gate.freq_lock_regulation_en;
    endproperty
    a_sleep0: assert property (p_sleep0)
        else $error("Sleep level zero gating is wrong.");

    property p_sleep1;
        @(posedge clk_sys) disable iff (reset)
        mode == lpm_pkg::sleep_level_one |=> !gate.cpu_en &&
            gate.aux_clk_en && gate.sub_main_clk_en &&
            gate.main_clk_en && !gate.freq_lock_regulation_en;
    endproperty
    a_sleep1: assert property (p_sleep1)
        else $error("Sleep level one gating is wrong.");

    property p_sleep2;
        @(posedge clk_sys) disable iff (reset)
        mode == lpm_pkg::sleep_level_two |=> !gate.cpu_en &&
            !gate.main_clk_en && !gate.freq_lock_regulation_en &&
            !gate.osc_clk_en && gate.dc_gen_en && gate.aux_clk_en;
    endproperty
    a_sleep2: assert property (p_sleep2)
        else $error("Sleep level two gating is wrong.");

    property p_sleep3;
        @(posedge clk_sys) disable iff (reset)
        mode == lpm_pkg::sleep_level_three |=> !gate.cpu_en &&
            !gate.main_clk_en && !gate.osc_clk_en && !gate.dc_gen_en &&
            gate.aux_clk_en && !gate.sub_main_clk_en;
    endproperty
    a_sleep3: assert property (p_sleep3)
        else $error("Sleep level three gating is wrong.");

    property p_sleep4;
        @(posedge clk_sys) disable iff (reset)
        mode == lpm_pkg::sleep_level_four |=> !(|gate);
    endproperty
    a_sleep4: assert property (p_sleep4)
        else $error("Sleep level four left something running.");
endmodule // mode_gate_decode

// file: rtl/power_mode_ctrl.sv
// Overview of operation
// - Software picks full run mode or one of five sleep levels.
// - An interrupt wakes any sleep level and its return re-enters it, unless the entry met a full stack or a return in the same cycle.
// - Full run mode runs every clock with the processor enabled.
// - Sleep level zero halts only the processor, all else keeps running.
// - Sleep level one is level zero with the frequency lock stopped.
// - Sleep level two stops main, sub-main, lock and oscillator; dc and aux stay.
// - Sleep level three also stops the dc generator; only aux and the crystal run.
// - Sleep level four stops everything, the crystal and aux included.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
module power_mode_ctrl #(
    parameter int NEST_DEPTH = lpm_pkg::NEST_DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic int_entry,
    input wire logic int_return,
    output logic cpu_en,
    output logic aux_clk_en,
    output logic sub_main_clk_en,
    output logic main_clk_en,
    output logic freq_lock_regulation_en,
    output logic osc_clk_en,
    output logic dc_gen_en,
    output logic crystal_en
);
    localparam int DEPTH_W = $clog2(NEST_DEPTH + 1);
    localparam logic [DEPTH_W-1:0] DEPTH_MAX = DEPTH_W'(NEST_DEPTH);
    localparam logic [DEPTH_W-1:0] DEPTH_ONE = DEPTH_W'(1);

    typedef struct packed {
        lpm_pkg::mode_t mode;
        lpm_pkg::mode_t [NEST_DEPTH-1:0] stack;
        logic [DEPTH_W-1:0] depth;
        logic bad_mode;
        logic ovf;
        logic unf;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;
    lpm_pkg::gate_t gate;
    lpm_pkg::mode_t saved_level;
    logic [lpm_pkg::MODE_W-1:0] wr_mode;

    reg_access_if ra ();

    axil_reg_port u_port (
        .clk_sys(clk_sys),
        .reset(reset),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .ra(ra)
    );

    mode_gate_decode u_decode (
        .clk_sys(clk_sys),
        .reset(reset),
        .mode(s_r.mode),
        .gate(gate)
    );

    assign wr_mode = ra.wdata[lpm_pkg::MODE_LSB +: lpm_pkg::MODE_W];
    assign saved_level = (s_r.depth == '0) ? lpm_pkg::full_run_mode :
        s_r.stack[s_r.depth - DEPTH_ONE];

    ////////////////////////////////////////////////////////////////////////
    // Software writes come first so that interrupt events override them.
    always_comb begin
        s_nxt = s_r;
        ra.wr_resp = lpm_pkg::RESP_OKAY;
        if (ra.wr_go) begin
            case (ra.wr_addr)
                lpm_pkg::MODE_CTRL_ADDR: begin
                    if (ra.wstrb[0]) begin
                        if (wr_mode <= lpm_pkg::MODE_LAST) begin
                            s_nxt.mode = lpm_pkg::mode_t'(wr_mode);
                        end else begin
                            s_nxt.bad_mode = 1'b1;
                            ra.wr_resp = lpm_pkg::RESP_SLVERR;
                        end
                    end
                end
                lpm_pkg::STATUS_ADDR: begin
                    s_nxt.mode = s_r.mode;
                end
                lpm_pkg::FAULT_ADDR: begin
                    if (ra.wstrb[0]) begin
                        s_nxt.bad_mode = s_r.bad_mode &
                            !ra.wdata[lpm_pkg::FAULT_BAD_MODE_BIT];
                        s_nxt.ovf = s_r.ovf &
                            !ra.wdata[lpm_pkg::FAULT_OVF_BIT];
                        s_nxt.unf = s_r.unf &
                            !ra.wdata[lpm_pkg::FAULT_UNF_BIT];
                    end
                end
                default: ra.wr_resp = lpm_pkg::RESP_DECERR;
            endcase
        end
        // A simultaneous entry and return forces full run and leaves stack and depth unchanged.
        if (int_entry && int_return) begin
            s_nxt.mode = lpm_pkg::full_run_mode;
        end else if (int_entry) begin
            if (s_r.depth < DEPTH_MAX) begin
                s_nxt.stack[s_r.depth] = s_r.mode;
                s_nxt.depth = s_r.depth + DEPTH_ONE;
            end else begin
                s_nxt.ovf = 1'b1;
            end
            s_nxt.mode = lpm_pkg::full_run_mode;
        end else if (int_return) begin
            if (s_r.depth != '0) begin
                s_nxt.mode = saved_level;
                s_nxt.depth = s_r.depth - DEPTH_ONE;
            end else begin
                s_nxt.unf = 1'b1;
            end
        end
    end

    always_comb begin
        ra.rdata = '0;
        ra.rd_resp = lpm_pkg::RESP_OKAY;
        case (ra.rd_addr)
            lpm_pkg::MODE_CTRL_ADDR: begin
                ra.rdata[lpm_pkg::MODE_LSB +: lpm_pkg::MODE_W] = s_r.mode;
            end
            lpm_pkg::STATUS_ADDR: begin
                ra.rdata[lpm_pkg::MODE_LSB +: lpm_pkg::MODE_W] = s_r.mode;
                ra.rdata[lpm_pkg::ST_SAVED_LSB +: lpm_pkg::MODE_W] =
                    saved_level;
                ra.rdata[lpm_pkg::ST_DEPTH_LSB +: lpm_pkg::ST_DEPTH_W] =
                    lpm_pkg::ST_DEPTH_W'(s_r.depth);
                ra.rdata[lpm_pkg::ST_GATE_LSB +: lpm_pkg::ST_GATE_W] = gate;
            end
            lpm_pkg::FAULT_ADDR: begin
                ra.rdata[lpm_pkg::FAULT_BAD_MODE_BIT] = s_r.bad_mode;
                ra.rdata[lpm_pkg::FAULT_OVF_BIT] = s_r.ovf;
                ra.rdata[lpm_pkg::FAULT_UNF_BIT] = s_r.unf;
            end
            default: ra.rd_resp = lpm_pkg::RESP_DECERR;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_r <= '0;
            s_r.mode <= lpm_pkg::MODE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cpu_en = gate.cpu_en;
    assign aux_clk_en = gate.aux_clk_en;
    assign sub_main_clk_en = gate.sub_main_clk_en;
    assign main_clk_en = gate.main_clk_en;
    assign freq_lock_regulation_en = gate.freq_lock_regulation_en;
    assign osc_clk_en = gate.osc_clk_en;
    assign dc_gen_en = gate.dc_gen_en;
    assign crystal_en = gate.crystal_en;

    ////////////////////////////////////////////////////////////////////////
    property p_mode_range;
        @(posedge clk_sys) disable iff (reset)
        s_r.mode <= lpm_pkg::MODE_LAST;
    endproperty
    a_mode_range: assert property (p_mode_range)
        else $error("Mode field holds an illegal level.");

    property p_sw_write;
        @(posedge clk_sys) disable iff (reset)
        ra.wr_go && ra.wr_addr == lpm_pkg::MODE_CTRL_ADDR && ra.wstrb[0] &&
            wr_mode <= lpm_pkg::MODE_LAST && !int_entry && !int_return
        |=> s_r.mode == $past(wr_mode) ##1
            cpu_en == ($past(s_r.mode) == lpm_pkg::full_run_mode);
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("Mode write did not take effect.");

    property p_entry_clears;
        @(posedge clk_sys) disable iff (reset)
        int_entry |=> s_r.mode == lpm_pkg::full_run_mode ##1 cpu_en;
    endproperty
    a_entry_clears: assert property (p_entry_clears)
        else $error("Interrupt entry did not restore full run.");

    property p_entry_saves;
        @(posedge clk_sys) disable iff (reset)
        int_entry && !int_return && s_r.depth < DEPTH_MAX |=>
            saved_level == $past(s_r.mode) &&
            s_r.depth == $past(s_r.depth) + DEPTH_ONE;
    endproperty
    a_entry_saves: assert property (p_entry_saves)
        else $error("Interrupt entry did not save the level.");

    property p_return_restores;
        @(posedge clk_sys) disable iff (reset)
        int_return && !int_entry && s_r.depth != '0 |=>
            s_r.mode == $past(saved_level);
    endproperty
    a_return_restores: assert property (p_return_restores)
        else $error("Interrupt return did not restore the level.");

    property p_wake_roundtrip;
        @(posedge clk_sys) disable iff (reset)
        (int_entry && !int_return && s_r.depth < DEPTH_MAX) ##1
            (int_return && !int_entry) |=> s_r.mode == $past(s_r.mode, 2);
    endproperty
    a_wake_roundtrip: assert property (p_wake_roundtrip)
        else $error("Sleep level lost across an interrupt.");

    c_wake_from_deep: cover property (@(posedge clk_sys) disable iff (reset)
        s_r.mode == lpm_pkg::sleep_level_four && int_entry);
    c_restore: cover property (@(posedge clk_sys) disable iff (reset)
        int_return && s_r.depth != '0 &&
        saved_level == lpm_pkg::sleep_level_three);
    c_nested: cover property (@(posedge clk_sys) disable iff (reset)
        int_entry && s_r.depth == DEPTH_ONE);
endmodule // power_mode_ctrl

// file: tb/cpu_irq_model.sv
`timescale 1ns/100ps
module cpu_irq_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cpu_en,
    input wire logic req_entry,
    input wire logic req_return,
    input wire logic [3:0] lag,
    output logic int_entry,
    output logic int_return
);
    logic pend_entry_r;
    logic pend_return_r;
    logic [3:0] cnt_r;

    always_ff @(posedge clk_sys) begin
        int_entry <= 1'b0;
        int_return <= 1'b0;
        if (reset) begin
            pend_entry_r <= 1'b0;
            pend_return_r <= 1'b0;
            cnt_r <= 4'h0;
        end else if (pend_entry_r || pend_return_r) begin
            if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end else if (pend_entry_r) begin
                // An interrupt is taken whatever the sleep level.
                int_entry <= 1'b1;
                pend_entry_r <= 1'b0;
            end else if (cpu_en) begin
                // A handler returns only while the processor runs.
                int_return <= 1'b1;
                pend_return_r <= 1'b0;
            end
        end else begin
            pend_entry_r <= req_entry;
            pend_return_r <= req_return;
            cnt_r <= lag;
        end
    end
endmodule // cpu_irq_model

// file: tb/low_power_mode_clock_gating_test.sv
`timescale 1ns/100ps
module low_power_mode_clock_gating_test;
    localparam int NEST = 2;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
    logic clk_sys, reset, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, int_entry, int_return;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb, lag;
    logic [1:0] bresp, rresp;
    logic cpu_en, aux_clk_en, sub_main_clk_en, main_clk_en;
    logic freq_lock_regulation_en, osc_clk_en, dc_gen_en, crystal_en;
    logic req_entry, req_return;
    integer seed = 32'h73569ab4;
    int miscompares = 0;
    int n_tests = 0;
    exp_t rq[$];
    logic [1:0] wq[$];
    lpm_pkg::mode_t stk[$];
    lpm_pkg::mode_t mode_exp = lpm_pkg::full_run_mode;
    logic [2:0] fault_exp = 3'h0;

    power_mode_ctrl #(.NEST_DEPTH(NEST)) u_power_mode_ctrl (
        .clk_sys(clk_sys), .reset(reset), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .int_entry(int_entry), .int_return(int_return), .cpu_en(cpu_en),
        .aux_clk_en(aux_clk_en), .sub_main_clk_en(sub_main_clk_en),
        .main_clk_en(main_clk_en), .osc_clk_en(osc_clk_en),
        .freq_lock_regulation_en(freq_lock_regulation_en),
        .dc_gen_en(dc_gen_en), .crystal_en(crystal_en));
    cpu_irq_model u_cpu_irq_model (
        .clk_sys(clk_sys), .reset(reset), .cpu_en(cpu_en),
        .req_entry(req_entry), .req_return(req_return), .lag(lag),
        .int_entry(int_entry), .int_return(int_return));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic lpm_pkg::gate_t gate_of(lpm_pkg::mode_t md);
        case (md)
            lpm_pkg::sleep_level_zero: return lpm_pkg::GATE_SLEEP0;
            lpm_pkg::sleep_level_one: return lpm_pkg::GATE_SLEEP1;
            lpm_pkg::sleep_level_two: return lpm_pkg::GATE_SLEEP2;
            lpm_pkg::sleep_level_three: return lpm_pkg::GATE_SLEEP3;
            lpm_pkg::sleep_level_four: return lpm_pkg::GATE_SLEEP4;
            default: return lpm_pkg::GATE_RUN;
        endcase
    endfunction

    // Results are compared as they appear, against the oldest note.
    always @(posedge clk_sys) begin
        exp_t e;
        if (bvalid && bready) begin
            check("bresp", 32'(bresp), 32'(wq.pop_front()));
        end
        if (rvalid && rready) begin
            e = rq.pop_front();
            check("rresp", {30'h0, rresp}, {30'h0, e.r});
            check("rdata", rdata & e.m, e.d);
        end
    end

    task automatic axi_write(logic [31:0] a, logic [31:0] d, logic [1:0] r,
            logic [3:0] s);
        wq.push_back(r);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic axi_read(logic [31:0] a, logic [31:0] d, logic [31:0] m,
            logic [1:0] r);
        rq.push_back('{d, m, r});
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    task automatic check_pins();
        check("gates", {24'h0, cpu_en, aux_clk_en, sub_main_clk_en,
            main_clk_en, freq_lock_regulation_en, osc_clk_en, dc_gen_en,
            crystal_en}, {24'h0, gate_of(mode_exp)});
    endtask

    task automatic read_status();
        logic [2:0] sv;
        sv = (stk.size() > 0) ? stk[$] : 3'h0;
        axi_read(lpm_pkg::STATUS_ADDR, {8'h0, gate_of(mode_exp), 4'h0,
            4'(stk.size()), 1'b0, sv, 1'b0, mode_exp}, 32'h00ff_0f77,
            lpm_pkg::RESP_OKAY);
    endtask

    task automatic set_mode(logic [2:0] md);
        axi_write(lpm_pkg::MODE_CTRL_ADDR, {24'($random(seed)), 5'h0, md},
            (md < 3'h6) ? lpm_pkg::RESP_OKAY : lpm_pkg::RESP_SLVERR,
            4'($random(seed)) | 4'h1);
        if (md < 3'h6) mode_exp = lpm_pkg::mode_t'(md);
        else fault_exp[0] = 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check_pins();
    endtask

    task automatic irq(logic enter);
        @(posedge clk_sys);
        req_entry <= enter;
        req_return <= !enter;
        lag <= 4'($random(seed));
        @(posedge clk_sys);
        req_entry <= 1'b0;
        req_return <= 1'b0;
        do @(posedge clk_sys); while (!(enter ? int_entry : int_return));
        if (enter) begin
            if (stk.size() < NEST) stk.push_back(mode_exp);
            else fault_exp[1] = 1'b1;
            mode_exp = lpm_pkg::full_run_mode;
        end else if (stk.size() > 0) begin
            mode_exp = stk.pop_back();
        end else begin
            fault_exp[2] = 1'b1;
        end
        @(posedge clk_sys);
        @(negedge clk_sys);
        check_pins();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(50 * 20000);
        miscompares++;
        close_out();
    end

    initial begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {req_entry, req_return} = 2'h0;
        awaddr = 32'h0;
        araddr = 32'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        lag = 4'h0;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        check_pins();
        read_status();
        for (int i = 0; i < 16; i++) begin
            set_mode((i < 8) ? 3'(i) : 3'(($random(seed) & 32'hff) % 6));
            read_status();
        end
        axi_read(lpm_pkg::FAULT_ADDR, {29'h0, fault_exp}, 32'h7,
            lpm_pkg::RESP_OKAY);
        axi_write(lpm_pkg::FAULT_ADDR, 32'h7, lpm_pkg::RESP_OKAY, 4'hf);
        fault_exp = 3'h0;
        axi_write(32'h10, 32'h5, lpm_pkg::RESP_DECERR, 4'hf);
        axi_read(32'h10, 32'h0, 32'h0, lpm_pkg::RESP_DECERR);
        axi_write(lpm_pkg::STATUS_ADDR, 32'h5, lpm_pkg::RESP_OKAY, 4'hf);
        axi_write(lpm_pkg::MODE_CTRL_ADDR, {29'h0, mode_exp ^ 3'h1},
            lpm_pkg::RESP_OKAY, 4'he);
        read_status();
        for (int md = 1; md < 6; md++) begin
            set_mode(3'(md));
            irq(1'b1);
            irq(1'b1);
            read_status();
            irq(1'b0);
            irq(1'b0);
            read_status();
        end
        set_mode(3'h0);
        irq(1'b0);
        for (int i = 0; i <= NEST; i++) irq(1'b1);
        axi_read(lpm_pkg::FAULT_ADDR, {29'h0, fault_exp}, 32'h7,
            lpm_pkg::RESP_OKAY);
        for (int i = 0; i < NEST; i++) irq(1'b0);
        read_status();
        repeat (4) @(posedge clk_sys);
        close_out();
    end
endmodule // low_power_mode_clock_gating_test
